// ===== pcg_pkg.sv
// Constants and types for the clock mode generator
`default_nettype none
package pcg_pkg;
  //////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int REG_AW = 16;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] CLOCK_MODE_CTL_OFFSET = 16'h0058;
  //////////////////////////////////////////////////////////////////////////////
  // Field positions of clock_mode_ctl
  localparam int MUL_LSB = 12;
  localparam int MUL_MSB = 15;
  localparam int HALF_BIT = 11;
  localparam int COUNT_LSB = 3;
  localparam int COUNT_MSB = 10;
  localparam int PLL_ON_BIT = 2;
  localparam int PLL_SEL_BIT = 1;
  localparam int STATUS_BIT = 0;
  localparam logic [3:0] MUL_UNITY = 4'hf;
  //////////////////////////////////////////////////////////////////////////////
  // Strap reset values, index is {pin a, pin b, pin c}
  localparam logic [15:0] RST_STRAP_000 = 16'h0000;
  localparam logic [15:0] RST_STRAP_001 = 16'h9007;
  localparam logic [15:0] RST_STRAP_010 = 16'h4007;
  localparam logic [15:0] RST_STRAP_100 = 16'h1007;
  localparam logic [15:0] RST_STRAP_110 = 16'hf007;
  localparam logic [15:0] RST_STRAP_111 = 16'h0000;
  localparam logic [15:0] RST_STRAP_101 = 16'hf000;
  localparam logic [15:0] RST_STRAP_011 = 16'h0000;
  localparam logic [15:0] RST_CLOCK_MODE = 16'h0000;
  //////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam int STRAP_WINDOW_CYCLES = 6;
  localparam int LOCK_PRESCALE_CYCLES = 16;
  localparam int DIV_BY_TWO = 2;
  localparam int DIV_BY_FOUR = 4;
  //////////////////////////////////////////////////////////////////////////////
  // Clock path state
  typedef enum logic [2:0] {
    PCG_DIV = 3'b001,
    PCG_ACQUIRE = 3'b010,
    PCG_LOCKED = 3'b100
  } pcg_state_t;
endpackage : pcg_pkg
`default_nettype wire

// ===== pcg_pin_sync.sv
// Three-stage synchroniser with agreement filter for strap pins
`default_nettype none
module pcg_pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Pins in, filtered levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  wire [WIDTH-1:0] nxt_level;

  if (WIDTH < 1) begin : g_bad_width
    $error("pcg_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // A change counts once the second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_filt
      assign nxt_level[gi] = (stage2_ff[gi] == stage3_ff[gi]) ? stage3_ff[gi] : level_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      level_ff <= '0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign pinOut = level_ff;
endmodule : pcg_pin_sync
`default_nettype wire

// ===== pcg_clock_mode_gen.sv
// Clock mode generator: strap-loaded mode register, divider, PLL lock timer
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
module pcg_clock_mode_gen
  import pcg_pkg::*;
#(
  parameter int LOCK_PRESCALE = LOCK_PRESCALE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Strap pins
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic mode_select_pin_c,
  // Register port
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [REG_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_DW-1:0] regRdData,
  // Clock generation outputs
  output logic masterClkEn,
  output logic oscEnable,
  output logic pllPowerOn,
  output logic pllAcquiring,
  output logic pllLocked,
  output logic clkFromPll,
  output logic [4:0] pllRatioNum,
  output logic [2:0] pllRatioDen,
  output logic strapBusy
);
  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int PRE_W = $clog2(LOCK_PRESCALE + 1);
  logic rstMeta_ff;
  logic rstN_ff;
  logic [2:0] pinLevel;
  logic [2:0] strapCnt_ff;
  logic strapWin;
  logic [15:0] mode_ff;
  logic [15:0] nxt_mode;
  logic modeWr;
  logic restartLock_ff;
  pcg_state_t state_ff;
  pcg_state_t nxt_state;
  logic [7:0] lockCnt_ff;
  logic [PRE_W-1:0] preCnt_ff;
  logic lockTick;
  logic [1:0] divCnt_ff;
  logic divEn;
  logic [REG_DW-1:0] rdData_ff;
  logic oscEn_ff;
  logic [4:0] num_ff;
  logic [2:0] den_ff;

  if (LOCK_PRESCALE < 1) begin : g_bad_prescale
    $error("pcg_clock_mode_gen: LOCK_PRESCALE must be >= 1");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap decode
  function automatic logic [15:0] strapValue(input logic [2:0] pins);
    logic [15:0] val;
    val = RST_STRAP_000;
    unique case (pins)
      3'h0: val = RST_STRAP_000;
      3'h1: val = RST_STRAP_001;
      3'h2: val = RST_STRAP_010;
      3'h4: val = RST_STRAP_100;
      3'h6: val = RST_STRAP_110;
      3'h7: val = RST_STRAP_111;
      3'h5: val = RST_STRAP_101;
      3'h3: val = RST_STRAP_011;
    endcase
    return val;
  endfunction : strapValue

  function automatic logic oscFromPins(input logic [2:0] pins);
    return pins != 3'h0;
  endfunction : oscFromPins

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rstN_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstN_ff <= rstMeta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap pin synchroniser
  pcg_pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(ref_clk),
    .rstN(rstN_ff),
    .pinIn({mode_select_pin_a, mode_select_pin_b, mode_select_pin_c}),
    .pinOut(pinLevel)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture window, reset still counted as held
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      strapCnt_ff <= 3'(STRAP_WINDOW_CYCLES);
    end else if (strapCnt_ff != 3'h0) begin
      strapCnt_ff <= strapCnt_ff - 3'h1;
    end
  end

  assign strapWin = strapCnt_ff != 3'h0;
  assign strapBusy = strapWin;

  //////////////////////////////////////////////////////////////////////////////
  // Mode register
  assign modeWr = regWr && !strapWin && regAddr == CLOCK_MODE_CTL_OFFSET;

  always_comb begin
    nxt_mode = mode_ff;
    if (strapWin) begin
      nxt_mode = strapValue(pinLevel);
    end else if (modeWr) begin
      nxt_mode = regWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      mode_ff <= RST_CLOCK_MODE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Any change of mode restarts acquisition
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      restartLock_ff <= 1'b1;
    end else begin
      restartLock_ff <= strapWin || modeWr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator enable tracks the pins, not the register
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      oscEn_ff <= 1'b0;
    end else begin
      oscEn_ff <= oscFromPins(pinLevel);
    end
  end

  assign oscEnable = oscEn_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Lock timer prescaler
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      preCnt_ff <= '0;
    end else if (restartLock_ff || state_ff != PCG_ACQUIRE) begin
      preCnt_ff <= '0;
    end else if (preCnt_ff == PRE_W'(LOCK_PRESCALE - 1)) begin
      preCnt_ff <= '0;
    end else begin
      preCnt_ff <= preCnt_ff + PRE_W'(1);
    end
  end

  assign lockTick = !restartLock_ff && state_ff == PCG_ACQUIRE
                    && preCnt_ff == PRE_W'(LOCK_PRESCALE - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Clock path state
  always_comb begin
    nxt_state = state_ff;
    if (restartLock_ff) begin
      if (mode_ff[PLL_SEL_BIT]) begin
        nxt_state = PCG_ACQUIRE;
      end else begin
        nxt_state = PCG_DIV;
      end
    end else begin
      unique case (state_ff)
        PCG_DIV: nxt_state = PCG_DIV;
        PCG_ACQUIRE: begin
          if (lockCnt_ff == 8'h0) begin
            nxt_state = PCG_LOCKED;
          end
        end
        PCG_LOCKED: nxt_state = PCG_LOCKED;
        default: nxt_state = PCG_DIV;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      state_ff <= PCG_DIV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Lock timer: loaded from the count field, one step per prescaled tick
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      lockCnt_ff <= 8'h0;
    end else if (restartLock_ff) begin
      lockCnt_ff <= mode_ff[COUNT_MSB:COUNT_LSB];
    end else if (lockTick && lockCnt_ff != 8'h0) begin
      lockCnt_ff <= lockCnt_ff - 8'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider path
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      divCnt_ff <= 2'h0;
    end else if (restartLock_ff || divEn) begin
      divCnt_ff <= 2'h0;
    end else begin
      divCnt_ff <= divCnt_ff + 2'h1;
    end
  end

  // Divide by four only with unity multiplier in divider mode
  always_comb begin
    if (state_ff == PCG_DIV && mode_ff[MUL_MSB:MUL_LSB] == MUL_UNITY) begin
      divEn = divCnt_ff == 2'(DIV_BY_FOUR - 1);
    end else begin
      divEn = divCnt_ff == 2'(DIV_BY_TWO - 1);
    end
  end

  // While acquiring the divided clock stays the master clock
  assign masterClkEn = (state_ff == PCG_LOCKED) ? 1'b1 : divEn;

  //////////////////////////////////////////////////////////////////////////////
  // PLL ratio and power
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      num_ff <= 5'h1;
      den_ff <= 3'h1;
    end else if (!mode_ff[HALF_BIT]) begin
      den_ff <= 3'h1;
      if (mode_ff[MUL_MSB:MUL_LSB] == MUL_UNITY) begin
        num_ff <= 5'h1;
      end else begin
        num_ff <= {1'b0, mode_ff[MUL_MSB:MUL_LSB]} + 5'h1;
      end
    end else if (!mode_ff[MUL_LSB]) begin
      num_ff <= {1'b0, mode_ff[MUL_MSB:MUL_LSB]} + 5'h1;
      den_ff <= 3'h2;
    end else begin
      num_ff <= {1'b0, mode_ff[MUL_MSB:MUL_LSB]};
      den_ff <= 3'h4;
    end
  end

  assign pllRatioNum = num_ff;
  assign pllRatioDen = den_ff;
  // PLL powered when selected, kept on, or still acquiring or locked
  assign pllPowerOn = mode_ff[PLL_SEL_BIT] || mode_ff[PLL_ON_BIT]
                      || state_ff != PCG_DIV;
  assign pllAcquiring = state_ff == PCG_ACQUIRE;
  assign pllLocked = state_ff == PCG_LOCKED;
  assign clkFromPll = state_ff == PCG_LOCKED;

  //////////////////////////////////////////////////////////////////////////////
  // Register read
  always_ff @(posedge ref_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      rdData_ff <= '0;
    end else if (regRd && regAddr == CLOCK_MODE_CTL_OFFSET) begin
      rdData_ff <= {mode_ff[15:1], state_ff == PCG_LOCKED};
    end else begin
      rdData_ff <= '0;
    end
  end

  assign regRdData = rdData_ff;
endmodule : pcg_clock_mode_gen
`default_nettype wire

// ===== pcg_checker_assertions.sv
// Concurrent checks on the clock mode generator ports
`default_nettype none
module pcg_checker
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Strap pins and register port
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic mode_select_pin_c,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [REG_DW-1:0] regRdData,
  // Clock outputs
  input wire logic masterClkEn,
  input wire logic oscEnable,
  input wire logic pllPowerOn,
  input wire logic pllAcquiring,
  input wire logic pllLocked,
  input wire logic clkFromPll,
  input wire logic strapBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  rd_stand_a: assert property (regRdData != 16'h0 |-> $past(regRd))
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property (
    regRd && regAddr != CLOCK_MODE_CTL_OFFSET |=> regRdData == 16'h0)
    else $error("unmapped read not zero");
  osc_off_a: assert property (
    (!mode_select_pin_a && !mode_select_pin_b && !mode_select_pin_c) [*8] |=> !oscEnable)
    else $error("oscillator on with pins low");
  osc_on_a: assert property (
    (mode_select_pin_a || mode_select_pin_b || mode_select_pin_c) [*8] |=> oscEnable)
    else $error("oscillator off with a pin high");
  lock_power_a: assert property (pllLocked |-> pllPowerOn)
    else $error("locked while powered down");
  lock_clken_a: assert property (pllLocked |-> masterClkEn)
    else $error("pll clock enable gap");
  div_pulse_a: assert property (
    masterClkEn && !pllLocked ##1 !pllLocked |-> !masterClkEn)
    else $error("divider pulses back to back");
  div_alive_a: assert property ((!pllLocked && !strapBusy && !regWr) [*5] |->
    masterClkEn || $past(masterClkEn) || $past(masterClkEn, 2) || $past(masterClkEn, 3))
    else $error("divider stalled");
  acq_first_a: assert property ($rose(pllLocked) |-> $past(pllAcquiring))
    else $error("lock without acquisition");
  lock_src_a: assert property (clkFromPll |-> pllLocked && !pllAcquiring)
    else $error("pll source before lock");
  lock_hold_a: assert property (pllLocked && !regWr && !$past(regWr) |=> pllLocked)
    else $error("lock dropped");
endmodule : pcg_checker
////////////////////////////////////////////////////////////////////////////////
bind pcg_clock_mode_gen pcg_checker i_pcg_checker (
  .ref_clk, .arst_n, .mode_select_pin_a, .mode_select_pin_b, .mode_select_pin_c,
  .regAddr, .regWr, .regRd, .regRdData, .masterClkEn, .oscEnable, .pllPowerOn,
  .pllAcquiring, .pllLocked, .clkFromPll, .strapBusy
);
`default_nettype wire

// ===== pcg_strap_src.sv
// Board strap model that drives the mode-select pins
`default_nettype none
module pcg_strap_src (
  // Requested strap code {pin a, pin b, pin c}
  input wire logic [2:0] code,
  // Strap pins
  output logic mode_select_pin_a,
  output logic mode_select_pin_b,
  output logic mode_select_pin_c
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reserved bypass code is never strapped, all low instead
  assign {mode_select_pin_a, mode_select_pin_b, mode_select_pin_c} =
    (code == 3'h3) ? 3'h0 : code;
endmodule : pcg_strap_src
`default_nettype wire

// ===== tb.sv
// Testbench for the clock mode generator
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcg_pkg::*;
  logic ref_clk, arst_n, regWr, regRd, mode_select_pin_a, mode_select_pin_b, mode_select_pin_c;
  logic masterClkEn, oscEnable, pllPowerOn, pllAcquiring, pllLocked, clkFromPll, strapBusy;
  logic [15:0] regAddr, regWrData, regRdData, rdVal;
  logic [4:0] pllRatioNum;
  logic [2:0] pllRatioDen, strapCode;
  int errTotal, checked, n;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};
  logic [15:0] vals [7] = '{16'h0, 16'h9007, 16'h4007, 16'h1007, 16'hf007, 16'h0, 16'hf000};
  logic [4:0] nums [7] = '{5'h1, 5'ha, 5'h5, 5'h2, 5'h1, 5'h1, 5'h1};
  ////////////////////////////////////////////////////////////////////////////////
  pcg_strap_src i_pcg_strap_src (.code(strapCode), .mode_select_pin_a, .mode_select_pin_b,
    .mode_select_pin_c);
  pcg_clock_mode_gen #(.LOCK_PRESCALE(2)) i_pcg_clock_mode_gen (.ref_clk, .arst_n,
    .mode_select_pin_a, .mode_select_pin_b, .mode_select_pin_c, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .masterClkEn, .oscEnable, .pllPowerOn, .pllAcquiring, .pllLocked,
    .clkFromPll, .pllRatioNum, .pllRatioDen, .strapBusy);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finishTest();
    $display("Checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finishTest
  task automatic bail(input int k);
    if (k >= 50) begin
      errTotal++;
      $display("BAD %0t wait ran out", $time);
      finishTest();
    end
  endtask : bail
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
  task automatic pulses(output logic [15:0] cnt);
    cnt = 16'h0;
    repeat (40) begin
      tick();
      cnt = cnt + {15'h0, masterClkEn};
    end
  endtask : pulses
  task automatic strapReset(input logic [2:0] c);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    strapCode <= c;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (n = 0; n < 50 && strapBusy !== 1'b0; n++) tick();
    bail(n);
    repeat (20) tick();
  endtask : strapReset
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    arst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 16'h0;
    regWrData = 16'h0;
    strapCode = 3'h0;
    for (int i = 0; i < 7; i++) begin
      strapReset(codes[i]);
      rd(16'h0058, rdVal);
      check(rdVal, vals[i]);
      check({15'h0, oscEnable}, {15'h0, codes[i] != 3'h0});
      check({11'h0, pllRatioNum}, {11'h0, nums[i]});
      check({13'h0, pllRatioDen}, 16'h1);
      pulses(rdVal);
      check(rdVal, vals[i][1] ? 16'h28 : (vals[i][15:12] == 4'hf ? 16'ha : 16'h14));
    end
    @(posedge ref_clk);
    strapCode <= 3'h0;
    repeat (10) tick();
    check({15'h0, oscEnable}, 16'h0);
    rd(16'h0058, rdVal);
    check(rdVal, 16'hf000);
    wr(16'h0058, 16'h2012);
    for (n = 0; n < 50 && pllAcquiring !== 1'b1; n++) tick();
    bail(n);
    for (n = 0; n < 50 && pllLocked !== 1'b1; n++) tick();
    check(16'(n), 16'h5);
    check({15'h0, clkFromPll}, 16'h1);
    bail(n);
    rd(16'h0058, rdVal);
    check(rdVal, 16'h2013);
    check({11'h0, pllRatioNum}, 16'h3);
    wr(16'h005a, 16'hffff);
    rd(16'h005a, rdVal);
    check(rdVal, 16'h0);
    rd(16'h0058, rdVal);
    check(rdVal, 16'h2013);
    wr(16'h0058, 16'hf000);
    repeat (4) tick();
    check({15'h0, pllPowerOn}, 16'h0);
    pulses(rdVal);
    check(rdVal, 16'ha);
    wr(16'h0058, 16'h5800);
    repeat (2) tick();
    check({11'h0, pllRatioNum}, 16'h5);
    check({13'h0, pllRatioDen}, 16'h4);
    wr(16'h0058, 16'h4800);
    repeat (2) tick();
    check({11'h0, pllRatioNum}, 16'h5);
    check({13'h0, pllRatioDen}, 16'h2);
    finishTest();
  end
endmodule : tb
`default_nettype wire
